// [design/nv_store.sv]
`timescale 1ns/1ps
`default_nettype none
// small nonvolatile image, registered read
module nv_store #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 32,
	parameter int AW = 5
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic wr_en,
	input wire logic [AW-1:0] addr,
	input wire logic [WIDTH-1:0] wr_data,
	output logic [WIDTH-1:0] rd_data
);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem; // stored words
		logic [WIDTH-1:0] rd; // read register
	} nv_mem_t;
	nv_mem_t st;
	nv_mem_t next_st;

	// read first, read returns the old word
	always_comb
	begin
		next_st = st;
		next_st.rd = st.mem[addr];
		if (wr_en)
			next_st.mem[addr] = wr_data;
	end

	// reset stands in for the factory-programmed image
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			for (int i = 0; i < DEPTH; i++)
				st.mem[i] <= supervisor_pkg::cfg_default(i);
			st.rd <= '0;
		end
		else
			st <= next_st;
	end

	assign rd_data = st.rd;
endmodule // nv_store
`default_nettype wire

// [design/supervisor_cfg.svh]
`ifndef SUPERVISOR_CFG_SVH
`define SUPERVISOR_CFG_SVH
// configuration word indices inside the operating image
`define CFG_IDX_SETUP0 5'h00
`define CFG_IDX_THR0 5'h06
`define CFG_IDX_GP 5'h0c
`define CFG_IDX_IO0 5'h0d
`define CFG_IDX_LOCK 5'h10
`define CFG_IDX_KEY 5'h11
`define CFG_WORDS 5'h12
// channel setup word fields
`define SETUP_RANGE_LSB 0
`define SETUP_POL_LO_BIT 7
`define SETUP_POL_HI_BIT 8
`define SETUP_RESET 16'h0101
`define THR_RESET 16'h0000
// threshold word fields
`define THR_HI_LSB 8
`define THR_LO_LSB 0
// range encodings
`define RANGE_HIGH 2'h0
`define RANGE_MED 2'h1
`define RANGE_LOW 2'h2
`define RANGE_PREC 2'h3
// range base and step in millivolts
`define HIGH_BASE_MV 14'h08ca
`define HIGH_STEP_MV 14'h0032
`define MED_BASE_MV 14'h0384
`define MED_STEP_MV 14'h0014
`define LOW_BASE_MV 14'h01c2
`define LOW_STEP_MV 14'h000a
`define PREC_BASE_MV 14'h00b4
`define PREC_STEP_MV 14'h0004
// general input word: one byte per input
`define GP_STRIDE 8
`define GP_MODE_LSB 0
`define GP_AUX_INV_BIT 3
`define GP_MR_CLR_BIT 4
`define GP_MODE_MR 3'h0
`define GP_MODE_AUXILIARY_COMPARATOR_INPUT 3'h1
`define GP_MODE_MARGIN_INPUT 3'h2
`define GP_MODE_UNDERVOLTAGE_IGNORE_INPUT 3'h3
// configurable pin word fields
`define IO_MAP_HI_BIT 0
`define IO_MAP_LO_BIT 1
`define IO_MAP_GP_LSB 2
`define IO_MAP_IO_LSB 4
`define IO_OUT_BIT 7
`define IO_PULLUP_BIT 8
`define IO_ALERT_BIT 9
`define IO_DLY_LSB 10
// timing defaults in ref_clk cycles
`define GLITCH_DEPTH_CYCLES 4
`define DOR_UNIT_CYCLES 200
`endif

// [design/supervisor_pkg.sv]
`default_nettype none
`include "supervisor_cfg.svh"
package supervisor_pkg;
	// host command codes carried over the link
	typedef enum logic [2:0] {OP_WRITE, OP_STORE, OP_RESTORE, OP_READ_LOG, OP_CLEAR_LOG, OP_ARA} cmd_op_t;
	// nonvolatile sequencer states
	typedef enum logic [1:0] {NV_IDLE, NV_LOAD, NV_STORE} nv_state_t;
	// factory image word for a given index
	function automatic logic [15:0] cfg_default(input int idx);
		if (idx < 6)
			return `SETUP_RESET;
		return `THR_RESET;
	endfunction
endpackage
`default_nettype wire

// [design/supply_supervisor_fault_logic.sv]
// Function
// - first channel high range: 2.25V plus 50mV steps
// - medium range all channels: 0.9V plus 20mV
// - low range channels 2-6: 0.45V plus 10mV
// - precision range channels 2-6: 0.18V plus 4mV
// - channel inputs reject short glitches
// - auxiliary comparator with selectable fault polarity
// - manual reset low may clear fault log
// - manual reset can map onto output pin
// - undervoltage-ignore low masks undervoltage faults
// - margin low masks upper and lower channel faults
// - outputs open-drain with optional weak pull-up
// - mapped sources OR together per pin
// - assert at once, release after delay
// - new fault restarts running release timer
// - alert cleared by alert response read
// - log read/clear clears alert unless persisting
// - write-lock ignores every write command except a lock-word write with matching key
// - lock bit writable with matching unlock code
// - store and load nonvolatile image anytime
// - power-up loads stored image automatically
// - commands ignored during nonvolatile transfer
// - upper fault follows upper polarity setting
`timescale 1ns/1ps
`default_nettype none
`include "supervisor_cfg.svh"
module supply_supervisor_fault_logic #(
	parameter int CHANNELS = 6,
	parameter int GPI_COUNT = 2,
	parameter int IO_COUNT = 3,
	parameter int GLITCH_DEPTH = `GLITCH_DEPTH_CYCLES,
	parameter logic [15:0] DOR_UNIT_CYCLES = `DOR_UNIT_CYCLES,
	parameter int NV_DEPTH = 32,
	parameter int NV_AW = 5
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic link_clk,
	input wire logic [CHANNELS-1:0] upper_above,
	input wire logic [CHANNELS-1:0] lower_above,
	input wire logic [GPI_COUNT-1:0] general_input_pin,
	input wire logic [GPI_COUNT-1:0] auxiliary_comparator_input,
	input wire logic [IO_COUNT-1:0] configurable_io_pin_in,
	output logic [IO_COUNT-1:0] configurable_io_pin_out,
	output logic [IO_COUNT-1:0] configurable_io_pin_oe,
	output logic [IO_COUNT-1:0] io_pullup_en,
	output logic [CHANNELS-1:0][13:0] upper_threshold_mv,
	output logic [CHANNELS-1:0][13:0] lower_threshold_mv,
	output logic [15:0] fault_status,
	output logic [15:0] fault_log,
	output logic nv_busy,
	output logic write_locked,
	output logic cmd_ignored,
	input wire logic link_cmd_valid,
	input wire logic [2:0] link_cmd_op,
	input wire logic [4:0] link_cmd_index,
	input wire logic [15:0] link_cmd_data,
	input wire logic [15:0] link_cmd_key,
	output logic link_cmd_ready
);
	localparam int RAW_W = 2 * CHANNELS + 2 * GPI_COUNT + IO_COUNT;
	localparam int GP_OFS = 2 * CHANNELS; // general input levels in raw vector
	localparam int AUX_OFS = GP_OFS + GPI_COUNT; // aux comparator outputs
	localparam int IO_OFS = AUX_OFS + GPI_COUNT; // pin input levels

	// link-side handshake state
	typedef struct packed {
		logic ack_s1; // ack toggle synchroniser stage one
		logic ack_s2; // ack toggle, safe to use
		logic busy; // request outstanding
		logic rdy; // registered ready
		logic req; // request toggle
		logic [2:0] op;
		logic [4:0] idx;
		logic [15:0] data;
		logic [15:0] key;
	} link_state_t;

	// core state on ref_clk
	typedef struct packed {
		logic [RAW_W-1:0] sync1; // first stage, read only by sync2
		logic [RAW_W-1:0] sync2;
		logic [2*CHANNELS-1:0][GLITCH_DEPTH-1:0] glitch; // sample history
		logic [2*CHANNELS-1:0] filt; // debounced comparator levels
		logic [`CFG_WORDS-1:0][15:0] cfg; // operating image
		logic [CHANNELS-1:0][13:0] thr_hi;
		logic [CHANNELS-1:0][13:0] thr_lo;
		logic [15:0] status;
		logic [15:0] log;
		logic [IO_COUNT-1:0] active; // pin condition incl. release delay
		logic [IO_COUNT-1:0] alert; // pending alert per pin
		logic [IO_COUNT-1:0] cond_d; // condition one cycle ago
		logic [IO_COUNT-1:0] oe;
		logic [IO_COUNT-1:0] pull;
		logic [IO_COUNT-1:0] drv; // open-drain data, always low
		logic [IO_COUNT-1:0][15:0] timer;
		supervisor_pkg::nv_state_t nv_state;
		logic [NV_AW-1:0] nv_idx;
		logic [NV_AW-1:0] nv_ridx;
		logic nv_rvalid;
		logic req_s1; // request toggle synchroniser
		logic req_s2;
		logic req_s3;
		logic ack;
		logic ignored;
		logic busy;
	} core_state_t;

	link_state_t l;
	link_state_t next_l;
	core_state_t st;
	core_state_t next_st;

	// threshold in millivolts; an illegal range falls back to medium
	function automatic logic [13:0] thr_mv(input int ch, input logic [1:0] rng, input logic [7:0] code);
		logic [1:0] r;
		r = rng;
		if (ch == 0 && r != `RANGE_HIGH)
			r = (r == `RANGE_MED) ? r : `RANGE_MED;
		else if (ch != 0 && r == `RANGE_HIGH)
			r = `RANGE_MED;
		case (r)
			`RANGE_HIGH: return `HIGH_BASE_MV + 14'(code) * `HIGH_STEP_MV;
			`RANGE_LOW: return `LOW_BASE_MV + 14'(code) * `LOW_STEP_MV;
			`RANGE_PREC: return `PREC_BASE_MV + 14'(code) * `PREC_STEP_MV;
			default: return `MED_BASE_MV + 14'(code) * `MED_STEP_MV;
		endcase
	endfunction

	// release delay: code 0 none, else unit doubled per step
	function automatic logic [15:0] dor_cycles(input logic [2:0] code);
		if (code == 3'h0)
			return 16'h0000;
		return DOR_UNIT_CYCLES << (code - 3'h1);
	endfunction

	// decoded fault picture, read by state update and checks
	logic [CHANNELS-1:0] up_f;
	logic [CHANNELS-1:0] lo_f;
	logic [GPI_COUNT-1:0] gp_src; // manual reset or aux fault per input
	logic margin; // any margin input held low
	logic uv_ign; // any undervoltage-ignore input held low
	logic mr_clr; // manual reset low with log clearing on
	logic [IO_COUNT-1:0] cond; // OR of mapped sources
	logic [IO_COUNT-1:0][15:0] dly;
	logic [15:0] stat_now;
	logic [15:0] nv_rd;
	logic nv_wr;
	logic [15:0] nv_wdata;
	logic new_cmd;
	logic cmd_take;
	logic wr_ok;
	logic alert_clr;

	// decode config against synchronised, filtered inputs
	always_comb
	begin
		logic [2:0] mode;
		logic pin;
		logic [15:0] w;
		mode = 3'h0;
		pin = 1'b1;
		w = 16'h0000;
		margin = 1'b0;
		uv_ign = 1'b0;
		mr_clr = 1'b0;
		gp_src = '0;
		stat_now = 16'h0000;
		for (int g = 0; g < GPI_COUNT; g++)
		begin
			mode = st.cfg[`CFG_IDX_GP][g*`GP_STRIDE+`GP_MODE_LSB +: 3];
			pin = st.sync2[GP_OFS+g];
			case (mode)
				`GP_MODE_MR:
				begin
					gp_src[g] = ~pin;
					mr_clr = mr_clr | (~pin & st.cfg[`CFG_IDX_GP][g*`GP_STRIDE+`GP_MR_CLR_BIT]);
				end
				`GP_MODE_AUXILIARY_COMPARATOR_INPUT: gp_src[g] = st.sync2[AUX_OFS+g] ^ st.cfg[`CFG_IDX_GP][g*`GP_STRIDE+`GP_AUX_INV_BIT];
				`GP_MODE_MARGIN_INPUT: margin = margin | ~pin;
				`GP_MODE_UNDERVOLTAGE_IGNORE_INPUT: uv_ign = uv_ign | ~pin;
				default: ;
			endcase
		end
		for (int c = 0; c < CHANNELS; c++)
		begin
			w = st.cfg[`CFG_IDX_SETUP0+c];
			up_f[c] = (st.filt[c] ~^ w[`SETUP_POL_HI_BIT]) & ~margin;
			lo_f[c] = (st.filt[CHANNELS+c] ~^ w[`SETUP_POL_LO_BIT]) & ~margin & ~uv_ign;
			stat_now[2*c+2] = up_f[c];
			stat_now[2*c+1] = lo_f[c];
		end
		for (int i = 0; i < IO_COUNT; i++)
		begin
			w = st.cfg[`CFG_IDX_IO0+i];
			dly[i] = dor_cycles(w[`IO_DLY_LSB +: 3]);
			cond[i] = (w[`IO_MAP_HI_BIT] & |up_f) | (w[`IO_MAP_LO_BIT] & |lo_f)
				| |(w[`IO_MAP_GP_LSB +: GPI_COUNT] & gp_src)
				| |(w[`IO_MAP_IO_LSB +: IO_COUNT] & st.sync2[IO_OFS +: IO_COUNT] & ~(IO_COUNT'(1) << i));
		end
	end

	// command intake is dropped while the image is moving
	assign new_cmd = st.req_s2 ^ st.req_s3;
	assign cmd_take = new_cmd && st.nv_state == supervisor_pkg::NV_IDLE;
	assign wr_ok = cmd_take && l.op == supervisor_pkg::OP_WRITE && l.idx < `CFG_WORDS
		&& (!st.cfg[`CFG_IDX_LOCK][0]
		|| (l.idx == `CFG_IDX_LOCK && l.key == st.cfg[`CFG_IDX_KEY]));
	assign alert_clr = cmd_take && (l.op == supervisor_pkg::OP_ARA
		|| l.op == supervisor_pkg::OP_READ_LOG || l.op == supervisor_pkg::OP_CLEAR_LOG);
	assign nv_wr = st.nv_state == supervisor_pkg::NV_STORE && st.nv_idx < `CFG_WORDS;
	assign nv_wdata = nv_wr ? st.cfg[st.nv_idx] : 16'h0000;

	nv_store #(
		.WIDTH(16),
		.DEPTH(NV_DEPTH),
		.AW(NV_AW)
	) u_nv (
		.ref_clk(ref_clk),
		.rst(rst),
		.wr_en(nv_wr),
		.addr(st.nv_idx),
		.wr_data(nv_wdata),
		.rd_data(nv_rd)
	);

	// link side: hold the command until the core acknowledges
	always_comb
	begin
		next_l = l;
		next_l.ack_s1 = st.ack;
		next_l.ack_s2 = l.ack_s1;
		if (l.busy && l.ack_s2 == l.req)
			next_l.busy = 1'b0;
		else if (!l.busy && link_cmd_valid)
		begin
			next_l.busy = 1'b1;
			next_l.req = ~l.req;
			next_l.op = link_cmd_op;
			next_l.idx = link_cmd_index;
			next_l.data = link_cmd_data;
			next_l.key = link_cmd_key;
		end
		next_l.rdy = ~next_l.busy;
	end

	// link registers; one cycle gap forced after each acknowledge
	always_ff @(posedge link_clk or posedge rst)
	begin
		if (rst)
		begin
			l <= '0;
			l.rdy <= 1'b1;
		end
		else
			l <= next_l;
	end

	// core update
	always_comb
	begin
		next_st = st;
		next_st.sync1 = {configurable_io_pin_in, auxiliary_comparator_input, general_input_pin,
			lower_above, upper_above};
		next_st.sync2 = st.sync1;
		for (int k = 0; k < 2 * CHANNELS; k++)
		begin
			next_st.glitch[k] = {st.glitch[k][GLITCH_DEPTH-2:0], st.sync2[k]};
			// level changes only after a full window agrees
			if (&st.glitch[k])
				next_st.filt[k] = 1'b1;
			else if (~|st.glitch[k])
				next_st.filt[k] = 1'b0;
		end
		for (int c = 0; c < CHANNELS; c++)
		begin
			next_st.thr_hi[c] = thr_mv(c, st.cfg[`CFG_IDX_SETUP0+c][`SETUP_RANGE_LSB +: 2],
				st.cfg[`CFG_IDX_THR0+c][`THR_HI_LSB +: 8]);
			next_st.thr_lo[c] = thr_mv(c, st.cfg[`CFG_IDX_SETUP0+c][`SETUP_RANGE_LSB +: 2],
				st.cfg[`CFG_IDX_THR0+c][`THR_LO_LSB +: 8]);
		end
		next_st.status = stat_now;
		// new faults win over any clear in the same cycle
		if (mr_clr || (cmd_take && l.op == supervisor_pkg::OP_CLEAR_LOG))
			next_st.log = stat_now;
		else
			next_st.log = st.log | stat_now;
		for (int i = 0; i < IO_COUNT; i++)
		begin
			if (cond[i])
			begin
				next_st.active[i] = 1'b1;
				next_st.timer[i] = dly[i];
			end
			else if (st.timer[i] != 16'h0000)
				next_st.timer[i] = st.timer[i] - 16'h0001;
			else
				next_st.active[i] = 1'b0;
			// clearing leaves the alert up while its cause remains
			if (cond[i] && !st.cond_d[i])
				next_st.alert[i] = 1'b1;
			else if (alert_clr)
				next_st.alert[i] = cond[i];
			next_st.cond_d[i] = cond[i];
			next_st.oe[i] = st.cfg[`CFG_IDX_IO0+i][`IO_OUT_BIT]
				& (st.cfg[`CFG_IDX_IO0+i][`IO_ALERT_BIT] ? next_st.alert[i] : next_st.active[i]);
			next_st.pull[i] = st.cfg[`CFG_IDX_IO0+i][`IO_PULLUP_BIT];
			next_st.drv[i] = 1'b0;
		end
		next_st.req_s1 = l.req;
		next_st.req_s2 = st.req_s1;
		next_st.req_s3 = st.req_s2;
		next_st.ack = st.req_s2;
		if (new_cmd)
			next_st.ignored = !cmd_take || (l.op == supervisor_pkg::OP_WRITE && !wr_ok);
		if (wr_ok)
			next_st.cfg[l.idx] = l.data;
		case (st.nv_state)
			supervisor_pkg::NV_IDLE:
			begin
				next_st.nv_idx = '0;
				next_st.nv_rvalid = 1'b0;
				if (cmd_take && l.op == supervisor_pkg::OP_STORE)
					next_st.nv_state = supervisor_pkg::NV_STORE;
				else if (cmd_take && l.op == supervisor_pkg::OP_RESTORE)
					next_st.nv_state = supervisor_pkg::NV_LOAD;
			end
			supervisor_pkg::NV_LOAD:
			begin
				// read data lags its address by one cycle
				if (st.nv_rvalid)
					next_st.cfg[st.nv_ridx] = nv_rd;
				next_st.nv_rvalid = 1'b0;
				if (st.nv_idx < `CFG_WORDS)
				begin
					next_st.nv_rvalid = 1'b1;
					next_st.nv_ridx = st.nv_idx;
					next_st.nv_idx = st.nv_idx + 5'h01;
				end
				else if (!st.nv_rvalid)
					next_st.nv_state = supervisor_pkg::NV_IDLE;
			end
			supervisor_pkg::NV_STORE:
			begin
				if (st.nv_idx < `CFG_WORDS)
					next_st.nv_idx = st.nv_idx + 5'h01;
				else
					next_st.nv_state = supervisor_pkg::NV_IDLE;
			end
			default: next_st.nv_state = supervisor_pkg::NV_IDLE;
		endcase
		next_st.busy = next_st.nv_state != supervisor_pkg::NV_IDLE;
	end

	// reset starts in load so the stored image comes up by itself
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			st <= '0;
			st.nv_state <= supervisor_pkg::NV_LOAD;
			st.busy <= 1'b1;
		end
		else
			st <= next_st;
	end

	assign configurable_io_pin_out = st.drv;
	assign configurable_io_pin_oe = st.oe;
	assign io_pullup_en = st.pull;
	assign upper_threshold_mv = st.thr_hi;
	assign lower_threshold_mv = st.thr_lo;
	assign fault_status = st.status;
	assign fault_log = st.log;
	assign nv_busy = st.busy;
	assign write_locked = st.cfg[`CFG_IDX_LOCK][0];
	assign cmd_ignored = st.ignored;
	assign link_cmd_ready = l.rdy;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	property p_thr_high;
		st.cfg[`CFG_IDX_SETUP0][1:0] == `RANGE_HIGH
		|=> st.thr_hi[0] == $past(`HIGH_BASE_MV + 14'(st.cfg[`CFG_IDX_THR0][15:8]) * `HIGH_STEP_MV);
	endproperty
	a_thr_high: assert property (p_thr_high) else $error("high range threshold wrong");
	property p_upper_pol;
		st.filt[0] && st.cfg[`CFG_IDX_SETUP0][`SETUP_POL_HI_BIT] && !margin |-> up_f[0];
	endproperty
	a_upper_pol: assert property (p_upper_pol) else $error("upper fault ignores polarity");
	property p_margin;
		margin |-> (up_f == '0 && lo_f == '0);
	endproperty
	a_margin: assert property (p_margin) else $error("fault seen while margining");
	property p_uv_ign;
		uv_ign |=> st.status[2*CHANNELS:1] == $past(stat_now[2*CHANNELS:1]) && lo_f == '0 || !uv_ign;
	endproperty
	a_uv_ign: assert property (p_uv_ign) else $error("undervoltage seen while ignored");
	property p_assert_now;
		cond[0] |=> st.active[0] && st.timer[0] == $past(dly[0]);
	endproperty
	a_assert_now: assert property (p_assert_now) else $error("pin not asserted or timer not loaded");
	property p_hold;
		st.active[0] && !cond[0] && st.timer[0] != 16'h0000 |=> st.active[0];
	endproperty
	a_hold: assert property (p_hold) else $error("pin released before delay");
	property p_release;
		st.active[0] && !cond[0] && st.timer[0] == 16'h0000 |=> !st.active[0];
	endproperty
	a_release: assert property (p_release) else $error("pin held after delay");
	property p_lock;
		cmd_take && l.op == supervisor_pkg::OP_WRITE && st.cfg[`CFG_IDX_LOCK][0]
		&& l.idx != `CFG_IDX_LOCK |=> st.cfg == $past(st.cfg);
	endproperty
	a_lock: assert property (p_lock) else $error("write taken while locked");
	property p_nv_ignore;
		new_cmd && st.nv_state != supervisor_pkg::NV_IDLE |=> st.ignored;
	endproperty
	a_nv_ignore: assert property (p_nv_ignore) else $error("command taken during transfer");
	property p_mr_clear;
		mr_clr && stat_now == 16'h0000 |=> st.log == 16'h0000;
	endproperty
	a_mr_clear: assert property (p_mr_clear) else $error("manual reset left log set");
	property p_alert_clear;
		alert_clr && !cond[0] |=> !st.alert[0];
	endproperty
	a_alert_clear: assert property (p_alert_clear) else $error("alert survived clear");
endmodule // supply_supervisor_fault_logic
`default_nettype wire

// [test/host_link_model.sv]
`timescale 1ns/1ps
`default_nettype none
// host end of the command link: one command at a time
module host_link_model (
	input wire logic link_clk,
	input wire logic link_cmd_ready,
	output logic link_cmd_valid,
	output logic [2:0] link_cmd_op,
	output logic [4:0] link_cmd_index,
	output logic [15:0] link_cmd_data,
	output logic [15:0] link_cmd_key
);
	int lapses; // waits that ran out of patience
	// idle link at time zero
	initial
	begin
		lapses = 0;
		link_cmd_valid = 1'b0;
		link_cmd_op = 3'h0;
		link_cmd_index = 5'h00;
		link_cmd_data = 16'h0000;
		link_cmd_key = 16'h0000;
	end
	// raise only on a free link: ready then stands high at the next edge, which takes it;
	// afterwards scramble the fields so stale data is never trusted
	task automatic send(input logic [2:0] op, input logic [4:0] idx, input logic [15:0] d,
		input logic [15:0] k);
		int n;
		n = 0;
		@(posedge link_clk);
		#1;
		while (link_cmd_ready !== 1'b1 && n < 50)
		begin
			@(posedge link_clk);
			#1;
			n++;
		end
		if (n >= 50)
			lapses++;
		link_cmd_valid = 1'b1;
		link_cmd_op = op;
		link_cmd_index = idx;
		link_cmd_data = d;
		link_cmd_key = k;
		// taking edge: ready was high before it and only a take lowers it
		@(posedge link_clk);
		#1;
		link_cmd_valid = 1'b0;
		link_cmd_op = ~op;
		link_cmd_index = ~idx;
		link_cmd_data = ~d;
		link_cmd_key = ~k;
		// ready comes back once the core has acted
		n = 0;
		while (link_cmd_ready !== 1'b1 && n < 50)
		begin
			@(posedge link_clk);
			#1;
			n++;
		end
		if (n >= 50)
			lapses++;
	endtask
endmodule // host_link_model
`default_nettype wire

// [test/supply_supervisor_fault_logic_test.sv]
`timescale 1ns/1ps
`default_nettype none
module supply_supervisor_fault_logic_test;
	logic ref_clk, link_clk, rst;
	logic [5:0] upper_above, lower_above; // comparator levels
	logic [1:0] general_input_pin, auxiliary_comparator_input;
	wire logic [2:0] io_in, io_out, io_oe, io_pu;
	logic [5:0][13:0] upper_threshold_mv, lower_threshold_mv;
	logic [15:0] fault_status, fault_log;
	logic nv_busy, write_locked, cmd_ignored;
	wire logic vld, rdy;
	wire logic [2:0] op;
	wire logic [4:0] idx;
	wire logic [15:0] dat, key;
	int failures, checks_done;
	int seed;
	logic [7:0] hi, lo;
	logic [15:0] k;
	logic [1:0] res [2];
	// pins are pulled up outside, so a pin reads low only while pulled
	assign io_in = ~io_oe;
	supply_supervisor_fault_logic #(.DOR_UNIT_CYCLES(16'h0004)) dut (.ref_clk(ref_clk),
		.rst(rst), .link_clk(link_clk), .upper_above(upper_above), .lower_above(lower_above),
		.general_input_pin(general_input_pin), .auxiliary_comparator_input(auxiliary_comparator_input),
		.configurable_io_pin_in(io_in), .configurable_io_pin_out(io_out),
		.configurable_io_pin_oe(io_oe), .io_pullup_en(io_pu),
		.upper_threshold_mv(upper_threshold_mv), .lower_threshold_mv(lower_threshold_mv),
		.fault_status(fault_status), .fault_log(fault_log), .nv_busy(nv_busy),
		.write_locked(write_locked), .cmd_ignored(cmd_ignored), .link_cmd_valid(vld),
		.link_cmd_op(op), .link_cmd_index(idx), .link_cmd_data(dat), .link_cmd_key(key),
		.link_cmd_ready(rdy));
	host_link_model host (.link_clk(link_clk), .link_cmd_ready(rdy), .link_cmd_valid(vld),
		.link_cmd_op(op), .link_cmd_index(idx), .link_cmd_data(dat), .link_cmd_key(key));
	// 5 ns core clock
	initial
	begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	// 48 ns link clock, phase unrelated
	initial
	begin
		link_clk = 1'b0;
		#7;
		forever #24 link_clk = ~link_clk;
	end
	task automatic wrap_up();
		failures = failures + host.lapses;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			failures++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(negedge ref_clk);
	endtask
	task automatic wr(input logic [4:0] i, input logic [15:0] d);
		host.send(3'h0, i, d, 16'h0000);
		step(2);
	endtask
	// pin 0 must hold its level every cycle
	task automatic watch(input int n, input logic e);
		repeat (n)
		begin
			step(1);
			chk({15'h0000, io_oe[0]}, {15'h0000, e});
		end
	endtask
	// bounded wait for the image transfer to end
	task automatic idle_wait();
		int n;
		n = 0;
		while (nv_busy !== 1'b0 && n < 2000)
		begin
			step(1);
			n++;
		end
		chk({15'h0000, nv_busy}, 16'h0000);
	endtask
	// a range not offered on a channel reads as medium
	function automatic logic [13:0] exp_mv(input int ch, input logic [1:0] r, input logic [7:0] c);
		logic [1:0] e;
		e = ((ch == 0) ? r[1] : (r == 2'h0)) ? 2'h1 : r;
		case (e)
			2'h0: return 14'h08ca + 14'(c) * 14'h0032;
			2'h1: return 14'h0384 + 14'(c) * 14'h0014;
			2'h2: return 14'h01c2 + 14'(c) * 14'h000a;
			default: return 14'h00b4 + 14'(c) * 14'h0004;
		endcase
	endfunction
	// hang guard, far beyond the expected run
	initial
	begin
		#100000;
		failures++;
		wrap_up();
	end
	// main sequence
	initial
	begin
		failures = 0;
		checks_done = 0;
		seed = 32'hdf5a_d3c9;
		rst = 1'b1;
		upper_above = 6'h00;
		lower_above = 6'h3f;
		general_input_pin = 2'h3;
		auxiliary_comparator_input = 2'h0;
		repeat (3) @(posedge link_clk);
		@(negedge ref_clk);
		chk({13'h0000, nv_busy, io_oe[0], rdy}, 16'h0005);
		rst = 1'b0;
		idle_wait();
		chk({2'h0, upper_threshold_mv[3]}, 16'h0384);
		// all ranges on all channels, corner and random codes
		for (int ch = 0; ch < 6; ch++)
			for (int r = 0; r < 4; r++)
			begin
				hi = (r == 0) ? 8'hff : 8'($random(seed));
				lo = (r == 1) ? 8'h00 : 8'($random(seed));
				wr(5'(ch), {8'h01, 6'h00, 2'(r)});
				wr(5'(ch + 6), {hi, lo});
				chk({2'h0, upper_threshold_mv[ch]}, {2'h0, exp_mv(ch, 2'(r), hi)});
				chk({2'h0, lower_threshold_mv[ch]}, {2'h0, exp_mv(ch, 2'(r), lo)});
			end
		// park channel 5 with its input grounded
		wr(5'h05, 16'h01c0);
		wr(5'h0b, 16'h0000);
		lower_above[5] = 1'b0;
		step(12);
		chk(fault_status, 16'h0000);
		// pin 0: any upper fault, pull-up, delay code 3
		wr(5'h0d, 16'h0d81);
		chk({10'h000, io_pu, io_out}, 16'h0008);
		upper_above[2] = 1'b1;
		step(2);
		upper_above[2] = 1'b0;
		step(12);
		chk({15'h0000, io_oe[0]}, 16'h0000);
		upper_above[2] = 1'b1;
		step(12);
		chk({14'h0000, io_oe[0], fault_status[6]}, 16'h0003);
		upper_above[2] = 1'b0;
		watch(18, 1'b1);
		step(30);
		chk({15'h0000, io_oe[0]}, 16'h0000);
		upper_above[2] = 1'b1;
		step(12);
		upper_above[2] = 1'b0;
		watch(10, 1'b1);
		upper_above[2] = 1'b1;
		watch(8, 1'b1);
		upper_above[2] = 1'b0;
		watch(20, 1'b1);
		step(40);
		chk({15'h0000, io_oe[0]}, 16'h0000);
		// upper polarity turned round
		wr(5'h02, 16'h0001);
		step(12);
		chk(fault_status, 16'h0040);
		wr(5'h02, 16'h0101);
		// margin on input 0, undervoltage ignore on input 1
		wr(5'h0c, 16'h0302);
		lower_above[1] = 1'b0;
		upper_above[3] = 1'b1;
		step(12);
		chk(fault_status, 16'h0108);
		general_input_pin[1] = 1'b0;
		step(12);
		chk(fault_status, 16'h0100);
		general_input_pin[0] = 1'b0;
		step(12);
		chk(fault_status, 16'h0000);
		general_input_pin = 2'h3;
		lower_above[1] = 1'b1;
		upper_above[3] = 1'b0;
		// manual reset clearing the log, onto pin 1 with the aux input
		wr(5'h0c, 16'h0110);
		wr(5'h0e, 16'h008c);
		general_input_pin[0] = 1'b0;
		step(12);
		chk({fault_log[14:0], io_oe[1]}, 16'h0001);
		general_input_pin[0] = 1'b1;
		for (int inv = 0; inv < 2; inv++)
		begin
			wr(5'h0c, 16'h0110 | 16'(inv << 11));
			auxiliary_comparator_input[1] = 1'b0;
			step(12);
			res[inv][0] = io_oe[1];
			auxiliary_comparator_input[1] = 1'b1;
			step(12);
			res[inv][1] = io_oe[1];
		end
		chk({14'h0000, res[0] ^ res[1]}, 16'h0003);
		chk({15'h0000, ^res[0]}, 16'h0001);
		// pin 2 as alert on lower faults
		wr(5'h0e, 16'h0000);
		wr(5'h0f, 16'h0282);
		lower_above[4] = 1'b0;
		step(12);
		lower_above[4] = 1'b1;
		step(20);
		chk({15'h0000, io_oe[2]}, 16'h0001);
		host.send(3'h5, 5'h00, 16'h0000, 16'h0000);
		step(4);
		chk({15'h0000, io_oe[2]}, 16'h0000);
		lower_above[4] = 1'b0;
		step(12);
		host.send(3'h3, 5'h00, 16'h0000, 16'h0000);
		step(4);
		chk({15'h0000, io_oe[2]}, 16'h0001);
		lower_above[4] = 1'b1;
		step(12);
		host.send(3'h4, 5'h00, 16'h0000, 16'h0000);
		step(4);
		chk({fault_log[14:0], io_oe[2]}, 16'h0000);
		// write lock with a random unlock code
		k = 16'($random(seed));
		wr(5'h06, 16'h5500);
		wr(5'h11, k);
		wr(5'h10, 16'h0001);
		wr(5'h06, 16'haaaa);
		chk({14'h0000, write_locked, cmd_ignored}, 16'h0003);
		chk({2'h0, upper_threshold_mv[0]}, {2'h0, exp_mv(0, 2'h3, 8'h55)});
		host.send(3'h0, 5'h10, 16'h0000, k ^ 16'h0001);
		step(2);
		chk({15'h0000, write_locked}, 16'h0001);
		host.send(3'h0, 5'h10, 16'h0000, k);
		step(2);
		chk({15'h0000, write_locked}, 16'h0000);
		// store, overwrite, then load back
		wr(5'h06, 16'h1020);
		host.send(3'h1, 5'h00, 16'h0000, 16'h0000);
		idle_wait();
		wr(5'h06, 16'h3040);
		host.send(3'h2, 5'h00, 16'h0000, 16'h0000);
		idle_wait();
		step(4);
		chk({2'h0, upper_threshold_mv[0]}, {2'h0, exp_mv(0, 2'h3, 8'h10)});
		wrap_up();
	end
endmodule // supply_supervisor_fault_logic_test
`default_nettype wire
